//--- design/clpw_top.sv
// CAN low-power wake, transmit guard and receive time-stamp block
//
// What this block does
// - In Sleep the transmit output is forced recessive
// - In Idle the module stops only when stop-in-idle bit is set
// - In Sleep watch receive line; wake interrupt when enabled
// - Wake-up comes only from Sleep, never Idle or run
// - After wake the module stays disabled; waking frame is lost
// - Optional glitch filter on receive, enabled by config bit 14
// - One bit-time capture pulse after error-free end of frame
// - Capture pulses only while capture enable bit 3 is set
// - When enabled, capture channel takes the bit-time pulse, not its pin
// - Bus activity in Sleep sets wake flag bit 6; wake code only when bit 6 is enabled
`timescale 1ns/10ps
module clpw_top #(
    parameter int FILTER_CYCLES = clpw_pkg::FILTER_CYCLES
) (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    // APB slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic [31:0]      prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // Processor power state
    input  wire logic        cpu_sleep_i,
    input  wire logic        cpu_idle_i,
    // Protocol engine side
    input  wire logic        engine_tx_i,
    input  wire logic        frame_ok_i,
    input  wire logic        mode_change_i,
    // CAN pins
    input  wire logic        can_receive_pin_i,
    output logic             can_transmit_pin_o,
    // Timer capture channel
    input  wire logic        capture_pin_i,
    output logic             timestamp_capture_o,
    // Power control and interrupt
    output logic             module_clk_en_o,
    output logic             module_disabled_o,
    output logic             wake_o,
    output logic             irq_o
);
    typedef struct packed {
        logic [15:0] ctrl_one;
        logic [15:0] cfg_two;
        logic [15:0] bit_div;
        logic [7:0]  int_flags;
        logic [7:0]  int_en;
        logic        disabled;
        logic        in_sleep;
        logic        tx;
        logic        cap;
        logic        clk_en;
        logic        wake;
        logic        irq;
        logic [31:0] rdata;
        logic        ready;
        logic        slverr;
    } clpw_state_t;

    clpw_state_t st_ff;
    clpw_state_t nxt_st;
    clpw_pkg::clpw_pwr_t pwr;
    logic        bus_active;
    logic        stamp_pulse;
    logic        setup;
    logic        wake_evt;
    logic        cap_evt;
    logic [6:0]  icode;

    function automatic logic [6:0] code_of(input logic [7:0] f, input logic [7:0] e);
        logic [7:0] act;
        act = f & e;
        if (act[clpw_pkg::WAKE_FLAG_BIT]) begin
            code_of = clpw_pkg::ICODE_WAKE;
        end else if (act[clpw_pkg::CAPTURE_FLAG_BIT]) begin
            code_of = clpw_pkg::ICODE_CAPTURE;
        end else begin
            code_of = clpw_pkg::ICODE_NONE;
        end
    endfunction : code_of

    always_comb begin
        if (cpu_sleep_i) begin
            pwr = clpw_pkg::PWR_SLEEP;
        end else if (cpu_idle_i) begin
            pwr = clpw_pkg::PWR_IDLE;
        end else begin
            pwr = clpw_pkg::PWR_RUN;
        end
    end

    // Filter feeds wake detection only; frame reception sees the raw pin
    clpw_glitch_filter #(
        .MIN_CYCLES(FILTER_CYCLES)
    ) u_filter (
        .clk_i    (clk_i),
        .sys_rst_i(sys_rst_i),
        .enable_i (st_ff.cfg_two[clpw_pkg::WAKE_FILTER_BIT]),
        .rx_i     (can_receive_pin_i),
        .active_o (bus_active)
    );

    clpw_bit_timer u_bit_timer (
        .clk_i    (clk_i),
        .sys_rst_i(sys_rst_i),
        .div_i    (st_ff.bit_div),
        .start_i  (cap_evt),
        .pulse_o  (stamp_pulse)
    );

    assign setup    = psel_i && !penable_i;
    // Sleep only: Idle and run never produce a wake
    assign wake_evt = (pwr == clpw_pkg::PWR_SLEEP) && bus_active;
    assign cap_evt  = frame_ok_i && st_ff.ctrl_one[clpw_pkg::CAPTURE_EN_BIT]
                      && !st_ff.disabled;
    assign icode    = code_of(st_ff.int_flags, st_ff.int_en);

    always_comb begin
        nxt_st        = st_ff;
        nxt_st.ready  = 1'b0;
        nxt_st.slverr = 1'b0;
        nxt_st.in_sleep = (pwr == clpw_pkg::PWR_SLEEP);

        // Register access; answer ready in the cycle after setup
        if (setup) begin
            nxt_st.ready = 1'b1;
            nxt_st.rdata = 32'h0000_0000;
            unique case (paddr_i)
                clpw_pkg::ADDR_CTRL_ONE: begin
                    if (pwrite_i) nxt_st.ctrl_one = pwdata_i[15:0];
                    nxt_st.rdata = {16'h0000, st_ff.ctrl_one};
                end
                clpw_pkg::ADDR_CFG_TWO: begin
                    if (pwrite_i) nxt_st.cfg_two = pwdata_i[15:0];
                    nxt_st.rdata = {16'h0000, st_ff.cfg_two};
                end
                clpw_pkg::ADDR_BIT_DIV: begin
                    if (pwrite_i) nxt_st.bit_div = pwdata_i[15:0];
                    nxt_st.rdata = {16'h0000, st_ff.bit_div};
                end
                clpw_pkg::ADDR_INT_FLAGS: begin
                    // Read clears; write ones also clears
                    if (pwrite_i) begin
                        nxt_st.int_flags = st_ff.int_flags & ~pwdata_i[7:0];
                    end else begin
                        nxt_st.int_flags = 8'h00;
                    end
                    nxt_st.rdata = {24'h000000, st_ff.int_flags};
                end
                clpw_pkg::ADDR_INT_ENABLE: begin
                    if (pwrite_i) nxt_st.int_en = pwdata_i[7:0];
                    nxt_st.rdata = {24'h000000, st_ff.int_en};
                end
                clpw_pkg::ADDR_INT_CODE: begin
                    nxt_st.rdata = {25'h0, icode};
                end
                clpw_pkg::ADDR_STATUS: begin
                    if (pwrite_i) nxt_st.disabled = pwdata_i[0];
                    nxt_st.rdata = {28'h0000000, st_ff.wake, st_ff.in_sleep,
                                    st_ff.clk_en, st_ff.disabled};
                end
                default: begin
                    nxt_st.slverr = 1'b1;
                end
            endcase
        end

        // Hardware set wins over a clear in the same cycle
        if (wake_evt) begin
            nxt_st.int_flags[clpw_pkg::WAKE_FLAG_BIT] = 1'b1;
            nxt_st.disabled = 1'b1;
        end
        if (cap_evt) begin
            nxt_st.int_flags[clpw_pkg::CAPTURE_FLAG_BIT] = 1'b1;
        end
        if (mode_change_i && !(pwr == clpw_pkg::PWR_SLEEP)) begin
            nxt_st.disabled = 1'b0;
        end

        // Wake request leaves high while the flag is enabled and set
        nxt_st.wake = nxt_st.int_flags[clpw_pkg::WAKE_FLAG_BIT]
                      && st_ff.int_en[clpw_pkg::WAKE_FLAG_BIT];
        nxt_st.irq  = |(nxt_st.int_flags & st_ff.int_en);

        // Recessive is high; disabled module also stays off the bus
        nxt_st.tx = (pwr == clpw_pkg::PWR_SLEEP || nxt_st.disabled)
                    ? 1'b1 : engine_tx_i;

        unique case (pwr)
            clpw_pkg::PWR_SLEEP: nxt_st.clk_en = 1'b0;
            clpw_pkg::PWR_IDLE:  nxt_st.clk_en =
                !st_ff.ctrl_one[clpw_pkg::STOP_IN_IDLE_BIT];
            clpw_pkg::PWR_RUN:   nxt_st.clk_en = 1'b1;
            default:             nxt_st.clk_en = 1'b1;
        endcase

        // Capture channel source select
        nxt_st.cap = st_ff.ctrl_one[clpw_pkg::CAPTURE_EN_BIT]
                     ? stamp_pulse : capture_pin_i;
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_ff          <= '0;
            st_ff.ctrl_one <= clpw_pkg::CTRL_ONE_RST;
            st_ff.cfg_two  <= clpw_pkg::CFG_TWO_RST;
            st_ff.bit_div  <= clpw_pkg::BIT_DIV_RST;
            st_ff.int_en   <= clpw_pkg::INT_EN_RST;
            st_ff.disabled <= 1'b1;
            st_ff.tx       <= 1'b1;
            st_ff.clk_en   <= 1'b1;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata_o            = st_ff.rdata;
    assign pready_o            = st_ff.ready;
    assign pslverr_o           = st_ff.slverr;
    assign can_transmit_pin_o  = st_ff.tx;
    assign timestamp_capture_o = st_ff.cap;
    assign module_clk_en_o     = st_ff.clk_en;
    assign module_disabled_o   = st_ff.disabled;
    assign wake_o              = st_ff.wake;
    assign irq_o               = st_ff.irq;
endmodule : clpw_top

//--- pkg/clpw_pkg.sv
// Shared constants for the CAN low-power wake and time-stamp block
package clpw_pkg;
    // APB register byte offsets
    localparam logic [7:0] ADDR_CTRL_ONE   = 8'h00;
    localparam logic [7:0] ADDR_CFG_TWO    = 8'h04;
    localparam logic [7:0] ADDR_INT_FLAGS  = 8'h08;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_INT_CODE   = 8'h10;
    localparam logic [7:0] ADDR_STATUS     = 8'h14;
    localparam logic [7:0] ADDR_BIT_DIV    = 8'h18;
    // Field positions
    localparam int STOP_IN_IDLE_BIT   = 13;
    localparam int CAPTURE_EN_BIT     = 3;
    localparam int WAKE_FILTER_BIT    = 14;
    localparam int WAKE_FLAG_BIT      = 6;
    localparam int CAPTURE_FLAG_BIT   = 7;
    // Reset values
    localparam logic [15:0] CTRL_ONE_RST = 16'h0000;
    localparam logic [15:0] CFG_TWO_RST  = 16'h0000;
    localparam logic [7:0]  INT_EN_RST   = 8'h00;
    localparam logic [15:0] BIT_DIV_RST  = 16'h007C;
    // Interrupt code values
    localparam logic [6:0] ICODE_NONE    = 7'h40;
    localparam logic [6:0] ICODE_WAKE    = 7'h42;
    localparam logic [6:0] ICODE_CAPTURE = 7'h43;
    // Glitch filter: least accepted dominant width, in ns
    localparam int CLK_PERIOD_NS   = 8;
    localparam int FILTER_MIN_NS   = 200;
    localparam int FILTER_CYCLES   = (FILTER_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Power states of the processor
    typedef enum logic [1:0] {
        PWR_RUN,
        PWR_IDLE,
        PWR_SLEEP
    } clpw_pwr_t;
endpackage : clpw_pkg

//--- design/clpw_glitch_filter.sv
// Low-pass filter on the receive line for wake detection only
`timescale 1ns/10ps
module clpw_glitch_filter #(
    parameter int MIN_CYCLES = clpw_pkg::FILTER_CYCLES
) (
    input  wire logic clk_i,
    input  wire logic sys_rst_i,
    input  wire logic enable_i,
    input  wire logic rx_i,
    output logic      active_o
);
    typedef struct packed {
        logic [7:0] cnt;
        logic       act;
    } clpw_flt_t;

    clpw_flt_t st_ff;
    clpw_flt_t nxt_st;

    always_comb begin
        nxt_st     = st_ff;
        nxt_st.act = 1'b0;
        if (rx_i) begin
            nxt_st.cnt = 8'h00;
        end else if (!enable_i) begin
            nxt_st.act = 1'b1;
        end else if (st_ff.cnt >= 8'(MIN_CYCLES - 1)) begin
            nxt_st.act = 1'b1;
        end else begin
            nxt_st.cnt = st_ff.cnt + 8'h01;
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign active_o = st_ff.act;
endmodule : clpw_glitch_filter

//--- design/clpw_bit_timer.sv
// Bit-time pulse stretcher for the time-stamp capture output
`timescale 1ns/10ps
module clpw_bit_timer (
    input  wire logic        clk_i,
    input  wire logic        sys_rst_i,
    input  wire logic [15:0] div_i,
    input  wire logic        start_i,
    output logic             pulse_o
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        busy;
    } clpw_bt_t;

    clpw_bt_t st_ff;
    clpw_bt_t nxt_st;

    always_comb begin
        nxt_st = st_ff;
        if (start_i) begin
            nxt_st.busy = 1'b1;
            nxt_st.cnt  = div_i;
        end else if (st_ff.busy) begin
            if (st_ff.cnt == 16'h0000) begin
                nxt_st.busy = 1'b0;
            end else begin
                nxt_st.cnt = st_ff.cnt - 16'h0001;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign pulse_o = st_ff.busy;
endmodule : clpw_bit_timer

//--- tb/clpw_bus_model.sv
// CAN bus stand-in driving the receive line
`timescale 1ns/10ps
module clpw_bus_model (
    input  wire logic clk_i,
    output logic      rx_o
);
    // Recessive is the bus's idle level
    initial rx_o = 1'b1;
    // Dominant burst of n samples; short n mimics a glitch
    task automatic dominant(input int n);
        @(posedge clk_i);
        rx_o <= 1'b0;
        repeat (n) @(posedge clk_i);
        rx_o <= 1'b1;
    endtask : dominant
endmodule : clpw_bus_model

//--- tb/clpw_top_chk.sv
// Port-level checker for the CAN wake and time-stamp block
`timescale 1ns/10ps
module clpw_top_chk #(
    parameter int FILTER_CYCLES = 4
) (
    input wire logic        clk_i,
    input wire logic        sys_rst_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [7:0]  paddr_i,
    input wire logic [31:0] pwdata_i,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic        cpu_sleep_i,
    input wire logic        cpu_idle_i,
    input wire logic        frame_ok_i,
    input wire logic        mode_change_i,
    input wire logic        capture_pin_i,
    input wire logic        can_transmit_pin_o,
    input wire logic        timestamp_capture_o,
    input wire logic        module_clk_en_o,
    input wire logic        module_disabled_o,
    input wire logic        wake_o,
    input wire logic        irq_o
);
    logic [15:0] ctl_ff;
    logic [15:0] div_ff;
    logic [15:0] hi_ff;
    logic        wr;
    logic        stop;
    logic        cap_on;
    // Shadow of written control values, seen only from the bus
    assign wr     = psel_i && !penable_i && pwrite_i;
    assign stop   = cpu_sleep_i || (cpu_idle_i && ctl_ff[clpw_pkg::STOP_IN_IDLE_BIT]);
    assign cap_on = ctl_ff[clpw_pkg::CAPTURE_EN_BIT];
    always_ff @(posedge clk_i) begin
        if (sys_rst_i) begin
            ctl_ff <= clpw_pkg::CTRL_ONE_RST;
            div_ff <= clpw_pkg::BIT_DIV_RST;
            hi_ff  <= 16'h0000;
        end else begin
            if (wr && paddr_i == clpw_pkg::ADDR_CTRL_ONE) ctl_ff <= pwdata_i[15:0];
            if (wr && paddr_i == clpw_pkg::ADDR_BIT_DIV) div_ff <= pwdata_i[15:0];
            hi_ff <= timestamp_capture_o ? hi_ff + 16'h0001 : 16'h0000;
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);
    // Disabled and the transmit pin are set at the same edge
    property p_tx_rec;
        $past(cpu_sleep_i) || module_disabled_o |-> can_transmit_pin_o;
    endproperty
    a_tx_rec: assert property (p_tx_rec) else $error("tx not recessive");
    property p_clk_gate; 1'b1 |=> module_clk_en_o == !$past(stop); endproperty
    a_clk_gate: assert property (p_clk_gate) else $error("clock gate wrong");
    // Sleep is judged when the filtered activity is sampled
    property p_wake_src; $rose(wake_o) |-> $past(cpu_sleep_i); endproperty
    a_wake_src: assert property (p_wake_src) else $error("wake outside sleep");
    property p_wake_dis; $rose(wake_o) |-> module_disabled_o && irq_o; endproperty
    a_wake_dis: assert property (p_wake_dis) else $error("wake not disabled");
    property p_dis_hold;
        module_disabled_o && !mode_change_i && !(wr && paddr_i == clpw_pkg::ADDR_STATUS)
        |=> module_disabled_o;
    endproperty
    a_dis_hold: assert property (p_dis_hold) else $error("left disabled");
    property p_cap_go;
        frame_ok_i && cap_on && !module_disabled_o |-> ##[2:3] $rose(timestamp_capture_o);
    endproperty
    a_cap_go: assert property (p_cap_go) else $error("no capture pulse");
    property p_cap_len;
        $fell(timestamp_capture_o) && cap_on |-> hi_ff == div_ff + 16'h0001;
    endproperty
    a_cap_len: assert property (p_cap_len) else $error("pulse width wrong");
    property p_pin; !cap_on |=> timestamp_capture_o == $past(capture_pin_i); endproperty
    a_pin: assert property (p_pin) else $error("pin not routed");
    property p_err;
        psel_i && !penable_i && paddr_i > clpw_pkg::ADDR_BIT_DIV |=> pready_o && pslverr_o;
    endproperty
    a_err: assert property (p_err) else $error("no slave error");
    c_wake: cover property ($rose(wake_o));
    c_cap: cover property ($fell(timestamp_capture_o) && cap_on);
    c_err: cover property (pslverr_o);
endmodule : clpw_top_chk
bind clpw_top clpw_top_chk #(.FILTER_CYCLES(FILTER_CYCLES)) u_chk (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .cpu_sleep_i(cpu_sleep_i), .cpu_idle_i(cpu_idle_i),
    .frame_ok_i(frame_ok_i), .mode_change_i(mode_change_i), .capture_pin_i(capture_pin_i),
    .can_transmit_pin_o(can_transmit_pin_o), .timestamp_capture_o(timestamp_capture_o),
    .module_clk_en_o(module_clk_en_o), .module_disabled_o(module_disabled_o),
    .wake_o(wake_o), .irq_o(irq_o));

//--- tb/clpw_top_tb_top.sv
// Self-checking bench for the CAN wake and time-stamp block
`timescale 1ns/10ps
module clpw_top_tb_top;
    localparam int FC = 4;
    logic        clk_i = 1'b0, sys_rst_i = 1'b1, psel_i = 1'b0, penable_i = 1'b0;
    logic        pwrite_i = 1'b0, pready_o, pslverr_o, cpu_sleep_i = 1'b0, cpu_idle_i = 1'b0;
    logic [7:0]  paddr_i = 8'h00;
    logic [31:0] pwdata_i = 32'h0, prdata_o;
    logic        engine_tx_i = 1'b1, frame_ok_i = 1'b0, mode_change_i = 1'b0, rx;
    logic        capture_pin_i = 1'b0, tx, ts, clk_en, dis, wake_o, irq_o, rnd_en = 1'b0;
    logic [32:0] q[$];
    logic [32:0] n;
    int          n_mismatch = 0, num_checks = 0, cyc = 0;
    clpw_top #(.FILTER_CYCLES(FC)) u_dut (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
        .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
        .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .cpu_sleep_i(cpu_sleep_i), .cpu_idle_i(cpu_idle_i), .engine_tx_i(engine_tx_i),
        .frame_ok_i(frame_ok_i), .mode_change_i(mode_change_i), .can_receive_pin_i(rx),
        .can_transmit_pin_o(tx), .capture_pin_i(capture_pin_i), .timestamp_capture_o(ts),
        .module_clk_en_o(clk_en), .module_disabled_o(dis), .wake_o(wake_o), .irq_o(irq_o));
    clpw_bus_model u_bus (.clk_i(clk_i), .rx_o(rx));
    always #4 clk_i = ~clk_i;
    // Random engine bits make a forced-recessive check meaningful
    always @(posedge clk_i) begin
        engine_tx_i <= 1'($urandom);
        capture_pin_i <= rnd_en & 1'($urandom);
        cyc++;
        if (cyc == 5000) begin
            n_mismatch++;
            finish_test();
        end
    end
    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic bit1(input logic g, input logic e);
        chk({32'h0, g}, {32'h0, e});
    endtask : bit1
    task automatic wt(input int k);
        repeat (k) @(posedge clk_i);
        @(negedge clk_i);
    endtask : wt
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel_i <= 1'b1;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge clk_i);
        penable_i <= 1'b1;
        // Ready is judged at the rising edge, before the design updates
        do @(posedge clk_i); while (pready_o !== 1'b1);
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [32:0] e);
        q.push_back(e);
        apb(1'b0, a, 32'h0);
    endtask : rd
    // Read data taken at the edge that completes the access
    always @(posedge clk_i) begin
        if (pready_o === 1'b1 && psel_i && penable_i && !pwrite_i) begin
            if (q.size() == 0) chk(33'h0, 33'h1);
            else chk({pslverr_o, prdata_o}, q.pop_front());
        end
    end
    task automatic pulse_frame();
        @(posedge clk_i);
        frame_ok_i <= 1'b1;
        @(posedge clk_i);
        frame_ok_i <= 1'b0;
    endtask : pulse_frame
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : finish_test
    initial begin
        void'($urandom(32'h7FE8));
        repeat (16) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rd(clpw_pkg::ADDR_BIT_DIV, {17'h0, clpw_pkg::BIT_DIV_RST});
        rd(clpw_pkg::ADDR_STATUS, 33'h3);
        rd(8'h1C, 33'h1_0000_0000);
        apb(1'b1, clpw_pkg::ADDR_INT_ENABLE, 32'hC0);
        apb(1'b1, clpw_pkg::ADDR_CFG_TWO, 32'h4000);
        apb(1'b1, clpw_pkg::ADDR_STATUS, 32'h0);
        u_bus.dominant(8);
        wt(4);
        bit1(wake_o, 1'b0);
        @(posedge clk_i);
        cpu_sleep_i <= 1'b1;
        wt(2);
        repeat (6) begin
            bit1(tx, 1'b1);
            @(negedge clk_i);
        end
        u_bus.dominant(FC - 1);
        wt(4);
        bit1(wake_o, 1'b0);
        u_bus.dominant(FC);
        wt(3);
        bit1(wake_o, 1'b1);
        bit1(dis, 1'b1);
        @(posedge clk_i);
        cpu_sleep_i <= 1'b0;
        rd(clpw_pkg::ADDR_INT_CODE, {26'h0, clpw_pkg::ICODE_WAKE});
        rd(clpw_pkg::ADDR_INT_FLAGS, 33'h40);
        rd(clpw_pkg::ADDR_INT_FLAGS, 33'h0);
        @(posedge clk_i);
        cpu_idle_i <= 1'b1;
        u_bus.dominant(8);
        wt(3);
        bit1(wake_o, 1'b0);
        bit1(clk_en, 1'b1);
        apb(1'b1, clpw_pkg::ADDR_CTRL_ONE, 32'h2000);
        wt(2);
        bit1(clk_en, 1'b0);
        @(posedge clk_i);
        cpu_idle_i <= 1'b0;
        mode_change_i <= 1'b1;
        @(posedge clk_i);
        mode_change_i <= 1'b0;
        apb(1'b1, clpw_pkg::ADDR_BIT_DIV, 32'h7);
        apb(1'b1, clpw_pkg::ADDR_CTRL_ONE, 32'h8);
        rnd_en <= 1'b1;
        pulse_frame();
        n = 33'h0;
        repeat (16) begin
            @(negedge clk_i);
            n = n + {32'h0, ts};
        end
        chk(n, 33'h8);
        bit1(irq_o, 1'b1);
        rd(clpw_pkg::ADDR_INT_CODE, {26'h0, clpw_pkg::ICODE_CAPTURE});
        apb(1'b1, clpw_pkg::ADDR_INT_ENABLE, 32'h0);
        wt(1);
        bit1(irq_o, 1'b0);
        rd(clpw_pkg::ADDR_INT_FLAGS, 33'h80);
        apb(1'b1, clpw_pkg::ADDR_CTRL_ONE, 32'h0);
        pulse_frame();
        wt(20);
        rd(clpw_pkg::ADDR_INT_FLAGS, 33'h0);
        finish_test();
    end
endmodule : clpw_top_tb_top
